//--- rtl/rbp_top.sv
// Purpose: byte-wide register port, clock byte refresh and external ram bank select
// Assumes: bus pins and supply states are asynchronous, timekeeping ports are on clk_sys_in
// Notes: ram enables are decoded without a clock so they follow the pins at once
`timescale 1ns/1ns
`include "rbp_cfg.svh"
module rbp_top
    import rbp_pkg::*;
#(
    parameter int DATA_W = `RBP_DATA_W,
    parameter int ADDR_W = `RBP_ADDR_W
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // host bus pins
    input wire logic chip_enable_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic [ADDR_W-1:0] register_address_in,
    input wire logic [DATA_W-1:0] data_bus_in,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe_out,
    // external ram bank select
    input wire logic external_ram_select_n_in,
    input wire logic bank_select_in,
    output logic ram_enable_one_n_out,
    output logic ram_enable_two_n_out,
    // supply state
    input wire logic power_fail_in,
    input wire logic battery_backup_in,
    // timekeeping refresh port
    input wire logic update_valid_in,
    input wire logic [ADDR_W-1:0] update_addr_in,
    input wire logic [DATA_W-1:0] update_data_in,
    output logic update_ack_out,
    // timekeeping events
    input wire logic watchdog_timeout_in,
    input wire logic battery_low_in,
    // settings and requests to the timekeeping logic
    output logic [DATA_W-1:0] clock_control_out,
    output logic [DATA_W-1:0] watchdog_setting_out,
    output logic [DATA_W-1:0] century_out,
    output logic [4:0] days_in_month_out,
    output logic alarm_event_out,
    output logic watchdog_reset_req_out,
    output logic watchdog_irq_req_out
);
    localparam int SYNC_W = 3 + ADDR_W + DATA_W + 2;

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic ce_n_s;
    logic oe_n_s;
    logic we_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] din_s;
    logic pf_s;
    logic bb_s;
    logic blocked;
    rbp_bus_state_t state;
    rbp_bus_state_t next_state;
    logic [ADDR_W-1:0] cap_addr;
    logic [DATA_W-1:0] cap_data;
    logic commit;
    logic update_take;
    logic mem_wr_en;
    logic [ADDR_W-1:0] mem_wr_addr;
    logic [DATA_W-1:0] mem_wr_data;
    logic [DATA_W-1:0] mem_rd_data;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [DATA_W-1:0] shadow [`RBP_REG_COUNT];
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] next_flags;
    logic [DATA_W-1:0] flag_set;
    logic [DATA_W-1:0] flag_clear;
    logic alarm_hit;
    logic alarm_hit_q;
    logic clock_hold;

    // bcd leap test is only right through 2099, as 2100 is not a leap year
    function automatic logic [4:0] month_days(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        logic [4:0] days;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        case (month)
            8'h02: days = leap ? 5'd29 : 5'd28;
            8'h04, 8'h06, 8'h09, 8'h11: days = 5'd30;
            default: days = 5'd31;
        endcase
        return days;
    endfunction

    // pins come from another domain, two flops before use
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1 <= {3'h7, {ADDR_W{1'b0}}, {DATA_W{1'b0}}, 2'h3};
            sync2 <= {3'h7, {ADDR_W{1'b0}}, {DATA_W{1'b0}}, 2'h3};
        end else if (clk_en_in) begin
            sync1 <= {chip_enable_n_in, output_enable_n_in, write_enable_n_in,
                      register_address_in, data_bus_in, power_fail_in, battery_backup_in};
            sync2 <= sync1;
        end
    end

    assign {ce_n_s, oe_n_s, we_n_s, addr_s, din_s, pf_s, bb_s} = sync2;
    assign blocked = pf_s | bb_s;

    // bus phase decode
    always_comb begin
        next_state = BUS_IDLE;
        case (state)
            BUS_IDLE, BUS_READ, BUS_WRITE: begin
                if (blocked) begin
                    next_state = BUS_IDLE;
                end else if (!ce_n_s && !we_n_s) begin
                    next_state = BUS_WRITE;
                end else if (!ce_n_s) begin
                    next_state = BUS_READ;
                end else begin
                    next_state = BUS_IDLE;
                end
            end
            default: next_state = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= BUS_IDLE;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    // address and data are taken while the write lasts, last value wins
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cap_addr <= '0;
            cap_data <= '0;
        end else if (clk_en_in && next_state == BUS_WRITE) begin
            cap_addr <= addr_s;
            cap_data <= din_s;
        end
    end

    // commit at the earlier rising edge; a supply fault aborts it
    assign commit = (state == BUS_WRITE) && (next_state != BUS_WRITE) && !blocked;
    assign clock_hold = shadow[`RBP_OFS_CONTROL][`RBP_CTRL_WRITE_HOLD_BIT]
                      | shadow[`RBP_OFS_CONTROL][`RBP_CTRL_READ_HOLD_BIT];
    // host write wins the port, refresh retries next cycle
    // the requester holds valid through the ack edge, so no retake while ack is up
    assign update_take = update_valid_in && !update_ack_out && !commit && !clock_hold;
    assign mem_wr_en = commit | update_take;
    assign mem_wr_addr = commit ? cap_addr : update_addr_in;
    assign mem_wr_data = commit ? cap_data : update_data_in;

    rbp_regfile #(
        .WIDTH(DATA_W),
        .DEPTH(`RBP_REG_COUNT),
        .AW(ADDR_W)
    ) u_regfile (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .wr_en_in(mem_wr_en),
        .wr_addr_in(mem_wr_addr),
        .wr_data_in(mem_wr_data),
        .rd_addr_in(addr_s),
        .rd_data_out(mem_rd_data)
    );

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            update_ack_out <= 1'b0;
        end else if (clk_en_in) begin
            update_ack_out <= update_take;
        end
    end

    // copies of the bytes that steer logic, kept in step with the memory
    genvar gi;
    generate
        for (gi = 0; gi < `RBP_REG_COUNT; gi++) begin : g_shadow
            always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    shadow[gi] <= `RBP_SHADOW_RESET;
                end else if (clk_en_in && mem_wr_en && mem_wr_addr == ADDR_W'(gi)) begin
                    shadow[gi] <= mem_wr_data;
                end
            end
        end
    endgenerate

    // alarm on match of month, date, hours, minutes, seconds
    assign alarm_hit = shadow[`RBP_OFS_ALM_MONTH] == shadow[`RBP_OFS_MONTH]
                     && shadow[`RBP_OFS_ALM_DATE] == shadow[`RBP_OFS_DATE]
                     && shadow[`RBP_OFS_ALM_HOUR] == shadow[`RBP_OFS_HOUR]
                     && shadow[`RBP_OFS_ALM_MIN] == shadow[`RBP_OFS_MIN]
                     && shadow[`RBP_OFS_ALM_SEC] == shadow[`RBP_OFS_SEC];

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // reset bytes all match, so start high to avoid a false alarm edge
            alarm_hit_q <= 1'b1;
            alarm_event_out <= 1'b0;
        end else if (clk_en_in) begin
            alarm_hit_q <= alarm_hit;
            alarm_event_out <= alarm_hit && !alarm_hit_q;
        end
    end

    // flags: events set, host write of one clears, set wins
    always_comb begin
        flag_set = '0;
        flag_set[`RBP_FLAG_WDOG_BIT] = watchdog_timeout_in;
        flag_set[`RBP_FLAG_ALARM_BIT] = alarm_hit && !alarm_hit_q;
        flag_set[`RBP_FLAG_BATT_BIT] = battery_low_in;
        flag_clear = (commit && cap_addr == `RBP_OFS_FLAGS) ? cap_data : '0;
        next_flags = (flags & ~flag_clear) | flag_set;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags <= `RBP_FLAGS_RESET;
        end else if (clk_en_in) begin
            flags <= next_flags;
        end
    end

    // watchdog timeout routed by the steering bit
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            watchdog_reset_req_out <= 1'b0;
            watchdog_irq_req_out <= 1'b0;
        end else if (clk_en_in) begin
            watchdog_reset_req_out <= watchdog_timeout_in
                                    && shadow[`RBP_OFS_WATCHDOG][`RBP_WDOG_STEER_BIT];
            watchdog_irq_req_out <= watchdog_timeout_in
                                  && !shadow[`RBP_OFS_WATCHDOG][`RBP_WDOG_STEER_BIT];
        end
    end

    // settings handed to the timekeeping logic
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clock_control_out <= '0;
            watchdog_setting_out <= '0;
            century_out <= '0;
            days_in_month_out <= 5'd31;
        end else if (clk_en_in) begin
            clock_control_out <= shadow[`RBP_OFS_CONTROL];
            watchdog_setting_out <= shadow[`RBP_OFS_WATCHDOG];
            century_out <= shadow[`RBP_OFS_CENTURY];
            days_in_month_out <= month_days(shadow[`RBP_OFS_MONTH], shadow[`RBP_OFS_YEAR]);
        end
    end

    // read path: memory data is a cycle late, so the address follows it
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_addr_q <= '0;
        end else if (clk_en_in) begin
            rd_addr_q <= addr_s;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_bus_out <= '0;
            data_bus_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            data_bus_out <= (rd_addr_q == `RBP_OFS_FLAGS) ? flags : mem_rd_data;
            // drive only in a read with output enable low; write low floats
            data_bus_oe_out <= (next_state == BUS_READ) && !oe_n_s;
        end
    end

    // bank select is kept off the clock so ram enables track the pins directly;
    // the host keeps the two chip enables apart, nothing here arbitrates
    always_comb begin
        if (power_fail_in || battery_backup_in) begin
            ram_enable_one_n_out = 1'b1;
            ram_enable_two_n_out = 1'b1;
        end else if (external_ram_select_n_in) begin
            ram_enable_one_n_out = 1'b1;
            ram_enable_two_n_out = 1'b1;
        end else begin
            ram_enable_one_n_out = bank_select_in;
            ram_enable_two_n_out = !bank_select_in;
        end
    end
endmodule

//--- rtl/rbp_cfg.svh
// Purpose: constants of the byte-wide register port and bank select
// Assumes: included by bare name from rtl files
// Notes: offsets are register indices on the 4-bit address
`ifndef RBP_CFG_SVH
`define RBP_CFG_SVH

`define RBP_DATA_W 8
`define RBP_ADDR_W 4
`define RBP_REG_COUNT 16

`define RBP_OFS_FLAGS 4'h0
`define RBP_OFS_CENTURY 4'h1
`define RBP_OFS_ALM_SEC 4'h2
`define RBP_OFS_ALM_MIN 4'h3
`define RBP_OFS_ALM_HOUR 4'h4
`define RBP_OFS_ALM_DATE 4'h5
`define RBP_OFS_ALM_MONTH 4'h6
`define RBP_OFS_WATCHDOG 4'h7
`define RBP_OFS_CONTROL 4'h8
`define RBP_OFS_SEC 4'h9
`define RBP_OFS_MIN 4'ha
`define RBP_OFS_HOUR 4'hb
`define RBP_OFS_DATE 4'hd
`define RBP_OFS_MONTH 4'he
`define RBP_OFS_YEAR 4'hf

`define RBP_FLAG_WDOG_BIT 7
`define RBP_FLAG_ALARM_BIT 6
`define RBP_FLAG_BATT_BIT 4
`define RBP_CTRL_WRITE_HOLD_BIT 7
`define RBP_CTRL_READ_HOLD_BIT 6
`define RBP_WDOG_STEER_BIT 7

`define RBP_FLAGS_RESET 8'h00
`define RBP_SHADOW_RESET 8'h00
`define RBP_SYNC_STAGES 2

`endif

//--- rtl/rbp_pkg.sv
// Purpose: types of the byte-wide register port
// Assumes: nothing
// Notes: constants live in rbp_cfg.svh
package rbp_pkg;
    typedef enum {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } rbp_bus_state_t;
endpackage

//--- rtl/rbp_regfile.sv
// Purpose: sixteen-byte register memory with registered read data
// Assumes: one write port, one read port, same clock
// Notes: cells have no reset, contents are battery-held in the device
`timescale 1ns/1ns
module rbp_regfile #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // read port
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys_in) begin
        if (clk_en_in && wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else if (clk_en_in) begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule

//--- bench/rbp_top_asserts.sv
// Purpose: concurrent checks on the pins of the register port and bank select
// Assumes: one clock domain, reset active high
// Notes: float checks allow six clocks for the two-flop pin sync plus output flop
`timescale 1ns/1ns
module rbp_top_asserts #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // host pins
    input wire logic chip_enable_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic data_bus_oe_out,
    // bank select and supply
    input wire logic external_ram_select_n_in,
    input wire logic bank_select_in,
    input wire logic power_fail_in,
    input wire logic battery_backup_in,
    input wire logic ram_enable_one_n_out,
    input wire logic ram_enable_two_n_out,
    // refresh and watchdog
    input wire logic update_valid_in,
    input wire logic update_ack_out,
    input wire logic watchdog_timeout_in,
    input wire logic [DATA_W-1:0] watchdog_setting_out,
    input wire logic watchdog_reset_req_out,
    input wire logic watchdog_irq_req_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    supply_off_a: assert property ((power_fail_in || battery_backup_in) |-> ram_enable_one_n_out && ram_enable_two_n_out)
        else $error("ram enable low while supply bad");
    ext_off_a: assert property (external_ram_select_n_in |-> ram_enable_one_n_out && ram_enable_two_n_out)
        else $error("ram enable low while external select high");
    bank_pick_a: assert property (!(external_ram_select_n_in || power_fail_in || battery_backup_in) |->
        ram_enable_one_n_out == bank_select_in && ram_enable_two_n_out != bank_select_in)
        else $error("bank select decode wrong");
    read_drive_a: assert property ((!chip_enable_n_in && !output_enable_n_in && write_enable_n_in
        && !power_fail_in && !battery_backup_in) [*6] |-> data_bus_oe_out)
        else $error("read not driving data bus");
    deselect_float_a: assert property (chip_enable_n_in [*6] |-> !data_bus_oe_out)
        else $error("data bus driven while deselected");
    oe_float_a: assert property (output_enable_n_in [*6] |-> !data_bus_oe_out)
        else $error("data bus driven with output enable high");
    supply_float_a: assert property ((power_fail_in || battery_backup_in) [*6] |-> !data_bus_oe_out)
        else $error("data bus driven while supply bad");
    ack_pulse_a: assert property (update_ack_out |-> $past(update_valid_in) ##1 !update_ack_out)
        else $error("refresh ack without request or too long");
    wdog_reset_a: assert property (watchdog_timeout_in && watchdog_setting_out[7] |=>
        watchdog_reset_req_out && !watchdog_irq_req_out)
        else $error("watchdog reset request missing");
    wdog_irq_a: assert property (watchdog_timeout_in && !watchdog_setting_out[7] |=>
        watchdog_irq_req_out && !watchdog_reset_req_out)
        else $error("watchdog interrupt request missing");
endmodule

//--- bench/rbp_host_bfm.sv
// Purpose: host bus model driving the sram style pins
// Assumes: levels held five clocks or more so the pin sync sees them
// Notes: released data pins show the inverse of the last byte, not a held value
`timescale 1ns/1ns
module rbp_host_bfm (
    // clock
    input wire logic clk_in,
    // pins toward the port
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [3:0] addr_out,
    output logic [7:0] data_out,
    // read side
    input wire logic [7:0] data_in,
    input wire logic drive_in
);
    initial begin
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        we_n_out = 1'b1;
        addr_out = 4'h0;
        data_out = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // address set with the enables, kept past their rise
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_out <= a;
        data_out <= d;
        ce_n_out <= 1'b0;
        we_n_out <= 1'b0;
        hold(5);
        ce_n_out <= 1'b1;
        we_n_out <= 1'b1;
        hold(1);
        data_out <= ~d;
        hold(4);
    endtask

    // write enable stays high through a read
    task automatic rd(input logic [3:0] a, input logic oe_n, output logic [7:0] q, output logic o);
        addr_out <= a;
        ce_n_out <= 1'b0;
        oe_n_out <= oe_n;
        hold(6);
        q = data_in;
        o = drive_in;
        ce_n_out <= 1'b1;
        oe_n_out <= 1'b1;
        hold(5);
    endtask
endmodule

//--- bench/tb_top.sv
// Purpose: self-checking bench of the register port and bank select
// Assumes: 20 MHz clock, host model holds every pin level several clocks
// Notes: memory cells have no reset, so each byte is written before it is read
`timescale 1ns/1ns
module tb_top;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic chip_enable_n_in, output_enable_n_in, write_enable_n_in, data_bus_oe_out, update_ack_out;
    logic [3:0] register_address_in;
    logic [3:0] update_addr_in = 4'h0;
    logic [7:0] data_bus_in, data_bus_out, clock_control_out, watchdog_setting_out, century_out;
    logic [7:0] update_data_in = 8'h00;
    logic ram_enable_one_n_out, ram_enable_two_n_out, alarm_event_out, watchdog_reset_req_out, watchdog_irq_req_out;
    logic external_ram_select_n_in = 1'b1, bank_select_in = 1'b0, power_fail_in = 1'b0, battery_backup_in = 1'b0;
    logic update_valid_in = 1'b0, watchdog_timeout_in = 1'b0, battery_low_in = 1'b0;
    logic [4:0] days_in_month_out;
    int n_fail = 0, check_count = 0, n_alarm = 0, n_rst = 0, n_irq = 0;

    always #25 clk_sys_in = ~clk_sys_in;

    always @(posedge clk_sys_in) begin
        n_alarm += int'(alarm_event_out === 1'b1);
        n_rst += int'(watchdog_reset_req_out === 1'b1);
        n_irq += int'(watchdog_irq_req_out === 1'b1);
    end

    rbp_top i_dut (.*);

    rbp_host_bfm i_host (.clk_in(clk_sys_in), .ce_n_out(chip_enable_n_in), .oe_n_out(output_enable_n_in),
        .we_n_out(write_enable_n_in), .addr_out(register_address_in), .data_out(data_bus_in),
        .data_in(data_bus_out), .drive_in(data_bus_oe_out));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // request held through the edge that shows ack, released just after it
    task automatic refresh(input logic [7:0] d, input logic want);
        int n;
        update_addr_in <= 4'h9;
        update_data_in <= d;
        update_valid_in <= 1'b1;
        for (n = 0; n < 10; n++) begin
            @(posedge clk_sys_in);
            if (update_ack_out === 1'b1) break;
        end
        update_valid_in <= 1'b0;
        tick(2);
        chk("refresh ack", {7'h0, want}, {7'h0, n < 10});
    endtask

    initial begin
        logic [7:0] q;
        logic o;
        logic [3:0] toff[5] = '{4'h9, 4'ha, 4'hb, 4'hd, 4'he};
        logic [7:0] mon[4] = '{8'h02, 8'h02, 8'h04, 8'h12};
        logic [7:0] yr[4] = '{8'h04, 8'h01, 8'h01, 8'h99};
        logic [7:0] dim[4] = '{8'd29, 8'd28, 8'd30, 8'd31};
        tick(12);
        sys_rst_in <= 1'b0;
        tick(3);
        // internal chip enable stays high while the external one is walked
        for (int i = 0; i < 16; i++) begin
            {battery_backup_in, power_fail_in, external_ram_select_n_in, bank_select_in} <= 4'(i);
            @(negedge clk_sys_in);
            chk("ram enables", {6'h0, i > 1 || i[0], i > 1 || !i[0]}, {6'h0, ram_enable_one_n_out, ram_enable_two_n_out});
            @(posedge clk_sys_in);
        end
        {battery_backup_in, power_fail_in, external_ram_select_n_in, bank_select_in} <= 4'b0010;
        tick(8);
        for (int i = 1; i < 16; i++) i_host.wr(4'(i), 8'(i) ^ 8'h30);
        for (int i = 1; i < 16; i++) begin
            i_host.rd(4'(i), 1'b0, q, o);
            chk("read byte", 8'(i) ^ 8'h30, q);
            chk("read drive", 8'h01, {7'h0, o});
        end
        chk("century", 8'h31, century_out);
        chk("watchdog setting", 8'h37, watchdog_setting_out);
        chk("clock control", 8'h38, clock_control_out);
        i_host.rd(4'h5, 1'b1, q, o);
        chk("float with oe high", 8'h00, {7'h0, o});
        for (int k = 0; k < 2; k++) begin
            {battery_backup_in, power_fail_in} <= k ? 2'b10 : 2'b01;
            tick(4);
            i_host.wr(4'h1, 8'hc5);
            i_host.rd(4'h1, 1'b0, q, o);
            chk("drive in supply fault", 8'h00, {7'h0, o});
            {battery_backup_in, power_fail_in} <= 2'b00;
            tick(4);
            i_host.rd(4'h1, 1'b0, q, o);
            chk("write in supply fault", 8'h31, q);
        end
        // a frozen clock enable must drop a whole write
        clk_en_in <= 1'b0;
        i_host.wr(4'h1, 8'h5a);
        clk_en_in <= 1'b1;
        i_host.rd(4'h1, 1'b0, q, o);
        chk("write while frozen", 8'h31, q);
        refresh(8'h59, 1'b1);
        i_host.rd(4'h9, 1'b0, q, o);
        chk("refreshed byte", 8'h59, q);
        i_host.wr(4'h8, 8'h80);
        refresh(8'h27, 1'b0);
        i_host.rd(4'h9, 1'b0, q, o);
        chk("held byte", 8'h59, q);
        for (int k = 0; k < 2; k++) begin
            i_host.wr(4'h7, k ? 8'h80 : 8'h00);
            watchdog_timeout_in <= 1'b1;
            tick(1);
            watchdog_timeout_in <= 1'b0;
            tick(3);
            chk("watchdog requests", k ? 8'h11 : 8'h01, {4'(n_rst), 4'(n_irq)});
        end
        battery_low_in <= 1'b1;
        tick(3);
        battery_low_in <= 1'b0;
        i_host.rd(4'h0, 1'b0, q, o);
        chk("flags", 8'h90, q & 8'h90);
        for (int j = 0; j < 4; j++) begin
            i_host.wr(4'he, mon[j]);
            i_host.wr(4'hf, yr[j]);
            tick(2);
            chk("days in month", dim[j], {3'h0, days_in_month_out});
        end
        // time bytes first, so the match only completes on the last alarm byte
        for (int j = 0; j < 5; j++) i_host.wr(toff[j], 8'(j + 1));
        for (int j = 0; j < 5; j++) i_host.wr(4'(j + 2), 8'(j + 1));
        tick(2);
        chk("alarm events", 8'h01, 8'(n_alarm));
        i_host.rd(4'h0, 1'b0, q, o);
        chk("alarm flag", 8'h40, q & 8'h40);
        i_host.wr(4'h0, 8'h40);
        i_host.rd(4'h0, 1'b0, q, o);
        chk("flag clear", 8'h90, q & 8'hd0);
        test_done();
    end
endmodule

bind rbp_top rbp_top_asserts #(.DATA_W(DATA_W)) u_chk (.*);
